// File: core/casr_regs.sv
`timescale 1ns/100ps
`include "casr_consts.svh"

// Behaviour
// - precharge entry sets charger-state alert bit 7 when enabled.
// - main charging phase entry sets bit 6 when enabled.
// - thermistor pause entry sets bit 5 when enabled.
// - charge-timer termination sets bit 4 when enabled.
// - fractional-current termination sets bit 3 when enabled.
// - maximum charge time fault sets bit 2 when enabled.
// - missing battery fault sets bit 1 when enabled.
// - shorted battery fault sets bit 0 when enabled.
// - host writes zero to clear a bit, ones elsewhere; only zeros clear.
// - clearing an enable bit also clears its alert.
// - alerts stay set until cleared or disabled.
// - six-bit regulation alert register at 0x38, enabled per bit, reset zero.
// - regulation bits: ilim, thermal, uvcl, iin limit, CC, CV.
// - read-only nine-bit live status register at 0x39.
// - status bit 8 high while the charger is active.
// - more than 8 cells selected sets bit 7 and inhibits charging.
// - cell count error forced true while measurement is disabled.
// - charger-state alerts form an 8-bit register at 0x37, with a 13-bit enable register at 0x1A.
module casr_regs
   import casr_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       srst,
   // two-wire serial port
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   // charger state machine, levels
   input  wire logic       in_precharge,
   input  wire logic       main_phase_flag,
   input  wire logic       in_ntc_pause,
   input  wire logic       in_timer_term,
   input  wire logic       in_cx_term,
   input  wire logic       in_max_time_fault,
   input  wire logic       bat_missing,
   input  wire logic       bat_short,
   // regulation loops, levels
   input  wire logic [5:0] regulation_active,
   // live conditions
   input  wire logic       charger_active,
   input  wire logic       measure_enabled,
   input  wire logic       stack_size_pin_a,
   input  wire logic       stack_size_pin_b,
   // charger control
   output logic            charge_inhibit
);

   // =======================================================================
   // pin synchronisers
   logic [1:0] pins_sync;
   logic [1:0] cells_n_sync;

   casr_sync #(.W(2)) u_sync (
      .clock    (clock),
      .srst     (srst),
      .async_in ({scl_in, sda_in}),
      .sync_out (pins_sync)
   );

   // cell pins enter inverted: the all-ones sync reset then reads as a
   // legal count, so no false inhibit pulse follows reset
   casr_sync #(.W(2)) u_cells_sync (
      .clock    (clock),
      .srst     (srst),
      .async_in (~{stack_size_pin_b, stack_size_pin_a}),
      .sync_out (cells_n_sync)
   );

   logic scl_s;
   logic sda_s;
   logic scl_prev_reg;
   logic sda_prev_reg;

   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   always_ff @(posedge clock) begin
      if (srst) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
      end
   end

   logic bus_start;
   logic bus_stop;
   logic scl_rise;
   logic scl_fall;

   assign bus_start = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
   assign bus_stop  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
   assign scl_rise  = scl_s && !scl_prev_reg;
   assign scl_fall  = !scl_s && scl_prev_reg;

   // =======================================================================
   // register storage
   logic [`CASR_CHG_W-1:0] en_chg_state_reg;
   logic [`CASR_REG_W-1:0] en_reg_status_reg;
   logic [`CASR_CHG_EVT_W-1:0] chg_alert;
   logic [`CASR_REG_W-1:0] regulation_alert_latches;
   logic [`CASR_SYS_W-1:0] live_system_condition_reg;
   logic [7:0]  cmd_reg;
   logic [15:0] wdata_reg;
   logic        wr_pulse_reg;

   // =======================================================================
   // write decode
   logic wr_chg;
   logic wr_reg;

   assign wr_chg = wr_pulse_reg && (cmd_reg == `CASR_CMD_CHG_STATE);
   assign wr_reg = wr_pulse_reg && (cmd_reg == `CASR_CMD_REG_STATUS);

   always_ff @(posedge clock) begin
      if (srst) begin
         en_chg_state_reg  <= `CASR_CHG_RST;
         en_reg_status_reg <= `CASR_REG_RST;
      end else if (wr_pulse_reg) begin
         if (cmd_reg == `CASR_CMD_EN_CHG_STATE) begin
            en_chg_state_reg <= wdata_reg[`CASR_CHG_W-1:0];
         end
         if (cmd_reg == `CASR_CMD_EN_REG_STATUS) begin
            en_reg_status_reg <= wdata_reg[`CASR_REG_W-1:0];
         end
      end
   end

   // =======================================================================
   // condition edge detection: only entry into a state raises an alert
   logic [`CASR_CHG_EVT_W-1:0] chg_level;
   logic [`CASR_CHG_EVT_W-1:0] chg_prev_reg;
   logic [`CASR_REG_W-1:0]     reg_prev_reg;

   always_comb begin
      chg_level                     = '0;
      chg_level[`CASR_CHG_PRECHG]   = in_precharge;
      chg_level[`CASR_CHG_MAIN]     = main_phase_flag;
      chg_level[`CASR_CHG_NTC]      = in_ntc_pause;
      chg_level[`CASR_CHG_TIMER]    = in_timer_term;
      chg_level[`CASR_CHG_CX]       = in_cx_term;
      chg_level[`CASR_CHG_MAXTIME]  = in_max_time_fault;
      chg_level[`CASR_CHG_MISSING]  = bat_missing;
      chg_level[`CASR_CHG_SHORT]    = bat_short;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         chg_prev_reg <= '0;
         reg_prev_reg <= '0;
      end else begin
         chg_prev_reg <= chg_level;
         reg_prev_reg <= regulation_active;
      end
   end

   // =======================================================================
   // sticky alert latches
   // enable gates both set and hold, so a disabled event leaves no trace
   casr_alert_bank #(.W(`CASR_CHG_EVT_W)) u_chg_alerts (
      .clock      (clock),
      .srst       (srst),
      .event_in   (chg_level & ~chg_prev_reg),
      .enable     (en_chg_state_reg[`CASR_CHG_EVT_W-1:0]),
      .clear_we   (wr_chg),
      .clear_mask (wdata_reg[`CASR_CHG_EVT_W-1:0]),
      .alert      (chg_alert)
   );

   casr_alert_bank #(.W(`CASR_REG_W)) u_reg_alerts (
      .clock      (clock),
      .srst       (srst),
      .event_in   (regulation_active & ~reg_prev_reg),
      .enable     (en_reg_status_reg),
      .clear_we   (wr_reg),
      .clear_mask (wdata_reg[`CASR_REG_W-1:0]),
      .alert      (regulation_alert_latches)
   );

   // =======================================================================
   // live system status, never latched
   logic cells_over;

   assign cells_over = (~cells_n_sync == `CASR_CELLS_OVER);

   always_ff @(posedge clock) begin
      if (srst) begin
         live_system_condition_reg <= `CASR_SYS_RST;
         charge_inhibit            <= 1'b0;
      end else begin
         live_system_condition_reg <= '0;
         live_system_condition_reg[`CASR_SYS_EN_CHG] <=
            charger_active;
         live_system_condition_reg[`CASR_SYS_CELL_ERR] <=
            cells_over || !measure_enabled;
         charge_inhibit <= cells_over;
      end
   end

   // =======================================================================
   // read mux; unmapped codes read zero
   logic [15:0] rdata;

   always_comb begin
      rdata = 16'h0000;
      unique case (cmd_reg)
         `CASR_CMD_CHG_STATE:     rdata[`CASR_CHG_EVT_W-1:0] = chg_alert;
         `CASR_CMD_REG_STATUS:
            rdata[`CASR_REG_W-1:0] = regulation_alert_latches;
         `CASR_CMD_SYS_STATUS:
            rdata[`CASR_SYS_W-1:0] = live_system_condition_reg;
         `CASR_CMD_EN_CHG_STATE:  rdata[`CASR_CHG_W-1:0] = en_chg_state_reg;
         `CASR_CMD_EN_REG_STATUS: rdata[`CASR_REG_W-1:0] = en_reg_status_reg;
         default:                 rdata = 16'h0000;
      endcase
   end

   // =======================================================================
   // two-wire word protocol: addr, command, low byte, high byte
   casr_tw_state_t state_reg;
   logic [7:0]     shreg;
   logic [3:0]     bit_cnt;
   logic           rd_mode;
   logic           master_ack;

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg    <= CASR_IDLE;
         shreg        <= 8'h00;
         bit_cnt      <= 4'h0;
         rd_mode      <= 1'b0;
         master_ack   <= 1'b0;
         cmd_reg      <= 8'h00;
         wdata_reg    <= 16'h0000;
         wr_pulse_reg <= 1'b0;
         sda_oe_n     <= 1'b1;
         sda_out      <= 1'b0;
      end else begin
         wr_pulse_reg <= 1'b0;
         sda_out      <= 1'b0;
         if (bus_start) begin
            state_reg <= CASR_ADDR;
            bit_cnt   <= 4'h0;
            sda_oe_n  <= 1'b1;
         end else if (bus_stop) begin
            state_reg <= CASR_IDLE;
            sda_oe_n  <= 1'b1;
         end else begin
            unique case (state_reg)
               CASR_IDLE: begin
                  sda_oe_n <= 1'b1;
               end
               CASR_ADDR, CASR_CMD, CASR_WR_LO, CASR_WR_HI: begin
                  if (scl_rise) begin
                     shreg   <= {shreg[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == 4'h8) begin
                     bit_cnt  <= 4'h0;
                     sda_oe_n <= 1'b0;
                     unique case (state_reg)
                        CASR_ADDR: begin
                           if (shreg[7:1] == `CASR_SLAVE_ADDR) begin
                              rd_mode   <= shreg[0];
                              state_reg <= CASR_ACK_ADDR;
                           end else begin
                              sda_oe_n  <= 1'b1;
                              state_reg <= CASR_IDLE;
                           end
                        end
                        CASR_CMD: begin
                           cmd_reg   <= shreg;
                           state_reg <= CASR_ACK_CMD;
                        end
                        CASR_WR_LO: begin
                           wdata_reg[7:0] <= shreg;
                           state_reg      <= CASR_ACK_LO;
                        end
                        default: begin
                           // word complete: commit once
                           wdata_reg[15:8] <= shreg;
                           wr_pulse_reg    <= 1'b1;
                           state_reg       <= CASR_ACK_HI;
                        end
                     endcase
                  end
               end
               CASR_ACK_ADDR, CASR_ACK_CMD, CASR_ACK_LO, CASR_ACK_HI: begin
                  if (scl_fall) begin
                     sda_oe_n <= 1'b1;
                     unique case (state_reg)
                        CASR_ACK_ADDR: begin
                           if (rd_mode) begin
                              shreg     <= {rdata[6:0], 1'b0};
                              sda_oe_n  <= rdata[7];
                              bit_cnt   <= 4'h1;
                              state_reg <= CASR_RD_LO;
                           end else begin
                              state_reg <= CASR_CMD;
                           end
                        end
                        CASR_ACK_CMD: state_reg <= CASR_WR_LO;
                        CASR_ACK_LO:  state_reg <= CASR_WR_HI;
                        default:      state_reg <= CASR_IDLE;
                     endcase
                  end
               end
               CASR_RD_LO, CASR_RD_HI: begin
                  if (scl_fall) begin
                     if (bit_cnt == 4'h8) begin
                        sda_oe_n  <= 1'b1;
                        bit_cnt   <= 4'h0;
                        state_reg <= (state_reg == CASR_RD_LO) ?
                                     CASR_RACK_LO : CASR_RACK_HI;
                     end else begin
                        sda_oe_n <= shreg[7];
                        shreg    <= {shreg[6:0], 1'b0};
                        bit_cnt  <= bit_cnt + 4'h1;
                     end
                  end
               end
               CASR_RACK_LO, CASR_RACK_HI: begin
                  if (scl_rise) begin
                     master_ack <= !sda_s;
                  end else if (scl_fall) begin
                     // nack or end of word: release and wait for stop
                     if (master_ack && state_reg == CASR_RACK_LO) begin
                        shreg     <= {rdata[14:8], 1'b0};
                        sda_oe_n  <= rdata[15];
                        bit_cnt   <= 4'h1;
                        state_reg <= CASR_RD_HI;
                     end else begin
                        state_reg <= CASR_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

endmodule : casr_regs

// File: core/casr_consts.svh
`ifndef CASR_CONSTS_SVH
`define CASR_CONSTS_SVH

// ==========================================================================
// command codes
`define CASR_CMD_CHG_STATE     8'h37
`define CASR_CMD_REG_STATUS    8'h38
`define CASR_CMD_SYS_STATUS    8'h39
`define CASR_CMD_EN_CHG_STATE  8'h1A
`define CASR_CMD_EN_REG_STATUS 8'h1B

// ==========================================================================
// field widths and positions
`define CASR_CHG_W         13
`define CASR_CHG_EVT_W     8
`define CASR_REG_W         6
`define CASR_SYS_W         9
`define CASR_SYS_EN_CHG    8
`define CASR_SYS_CELL_ERR  7
`define CASR_CHG_PRECHG    7
`define CASR_CHG_MAIN      6
`define CASR_CHG_NTC       5
`define CASR_CHG_TIMER     4
`define CASR_CHG_CX        3
`define CASR_CHG_MAXTIME   2
`define CASR_CHG_MISSING   1
`define CASR_CHG_SHORT     0

// ==========================================================================
// reset values and pin codes
`define CASR_CHG_RST       13'h0000
`define CASR_REG_RST       6'h00
`define CASR_SYS_RST       9'h000
`define CASR_CELLS_OVER    2'h3
`define CASR_SLAVE_ADDR    7'h10

`endif

// File: core/casr_pkg.sv
package casr_pkg;

   // serial port protocol phases
   typedef enum logic [3:0] {
      CASR_IDLE,
      CASR_ADDR,
      CASR_ACK_ADDR,
      CASR_CMD,
      CASR_ACK_CMD,
      CASR_WR_LO,
      CASR_ACK_LO,
      CASR_WR_HI,
      CASR_ACK_HI,
      CASR_RD_LO,
      CASR_RACK_LO,
      CASR_RD_HI,
      CASR_RACK_HI
   } casr_tw_state_t;

endpackage : casr_pkg

// File: core/casr_sync.sv
`timescale 1ns/100ps
module casr_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         srst,
   // asynchronous in, synchronous out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (srst) begin
         meta_reg <= '1;
         sync_out <= '1;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule : casr_sync

// File: core/casr_alert_bank.sv
`timescale 1ns/100ps
module casr_alert_bank #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         srst,
   // condition events, one-cycle pulses
   input  wire logic [W-1:0] event_in,
   // enables and host clear
   input  wire logic [W-1:0] enable,
   input  wire logic         clear_we,
   input  wire logic [W-1:0] clear_mask,
   // latched alerts
   output logic      [W-1:0] alert
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic keep;
         assign keep = alert[i] && !(clear_we && !clear_mask[i]);
         always_ff @(posedge clock) begin
            if (srst) begin
               alert[i] <= 1'b0;
            end else begin
               // set beats clear; no enable means nothing is held
               alert[i] <= enable[i] && (keep || event_in[i]);
            end
         end
      end
   endgenerate

endmodule : casr_alert_bank

// File: tb/casr_regs_chk.sv
`timescale 1ns/100ps
module casr_regs_chk (
   // clock and reset
   input  wire logic clock,
   input  wire logic srst,
   // serial port
   input  wire logic scl_in,
   input  wire logic sda_out,
   input  wire logic sda_oe_n,
   // cell pins and inhibit
   input  wire logic stack_size_pin_a,
   input  wire logic stack_size_pin_b,
   input  wire logic charge_inhibit
);
   // ============
   // sequences
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // five samples cover the two-flop pin sync plus the output register
   sequence s_over;
      (stack_size_pin_a && stack_size_pin_b)[*5];
   endsequence
   sequence s_under;
      (!(stack_size_pin_a && stack_size_pin_b))[*5];
   endsequence
   sequence s_scl_high;
      scl_in[*5];
   endsequence
   // ============
   // assertions
   a_inhibit_set: assert property (s_over |-> charge_inhibit)
      else $error("inhibit low with over-range cell pins");
   a_inhibit_clr: assert property (s_under |-> !charge_inhibit)
      else $error("inhibit high with legal cell pins");
   a_inhibit_cause: assert property ($rose(charge_inhibit) |->
      $past(stack_size_pin_a, 3) && $past(stack_size_pin_b, 3))
      else $error("inhibit rose without over-range pins");
   a_rst_quiet: assert property (disable iff (1'b0)
      srst |=> sda_oe_n && !charge_inhibit)
      else $error("outputs active after reset");
   a_sda_zero: assert property (sda_out == 1'b0)
      else $error("data output not low");
   a_scl_hold: assert property (s_scl_high |-> $stable(sda_oe_n))
      else $error("data drive changed while clock high");
   a_drive_low: assert property ($fell(sda_oe_n) |->
      !scl_in && !$past(scl_in, 2))
      else $error("data driven outside clock low phase");
   a_release_low: assert property (
      $rose(sda_oe_n) && !$past(srst) |-> !scl_in)
      else $error("data released while clock high");
endmodule : casr_regs_chk

bind casr_regs casr_regs_chk u_chk (
   .clock(clock), .srst(srst), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .stack_size_pin_a(stack_size_pin_a),
   .stack_size_pin_b(stack_size_pin_b), .charge_inhibit(charge_inhibit)
);

// File: tb/casr_host.sv
`timescale 1ns/100ps
module casr_host (
   // clock
   input  wire logic clock,
   // two-wire lines, sda pulled up by the bench
   input  wire logic sda,
   output logic      scl,
   output logic      sda_oe_n
);
   initial begin
      scl = 1'b1;
      sda_oe_n = 1'b1;
   end

   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
   endtask : wait_n

   // sda moves 3 clocks after scl falls so sync skew never fakes a start
   task automatic put_bit(input logic b, output logic r);
      wait_n(3);
      sda_oe_n <= b;
      wait_n(8);
      scl <= 1'b1;
      wait_n(10);
      r = sda;
      scl <= 1'b0;
   endtask : put_bit

   task automatic start_cond();
      wait_n(3);
      sda_oe_n <= 1'b1;
      wait_n(8);
      scl <= 1'b1;
      wait_n(10);
      sda_oe_n <= 1'b0;
      wait_n(10);
      scl <= 1'b0;
   endtask : start_cond

   task automatic stop_cond();
      wait_n(3);
      sda_oe_n <= 1'b0;
      wait_n(8);
      scl <= 1'b1;
      wait_n(10);
      sda_oe_n <= 1'b1;
      wait_n(10);
   endtask : stop_cond

   task automatic byte_io(input logic [7:0] tx, input logic mack,
                          output logic [7:0] rx, output logic nak);
      for (int i = 7; i >= 0; i--) begin
         put_bit(tx[i], rx[i]);
      end
      put_bit(mack, nak);
   endtask : byte_io

   // low byte first; the word commits only after the high byte
   task automatic write_word(input logic [6:0] addr, input logic [7:0] cmd,
                             input logic [15:0] data, output logic nak);
      logic [7:0] rx;
      logic [3:0] n;
      start_cond();
      byte_io({addr, 1'b0}, 1'b1, rx, n[0]);
      byte_io(cmd, 1'b1, rx, n[1]);
      byte_io(data[7:0], 1'b1, rx, n[2]);
      byte_io(data[15:8], 1'b1, rx, n[3]);
      stop_cond();
      nak = |n;
   endtask : write_word

   task automatic read_word(input logic [6:0] addr, input logic [7:0] cmd,
                            output logic [15:0] data, output logic nak);
      logic [7:0] rx;
      logic [2:0] n;
      logic       d;
      start_cond();
      byte_io({addr, 1'b0}, 1'b1, rx, n[0]);
      byte_io(cmd, 1'b1, rx, n[1]);
      start_cond();
      byte_io({addr, 1'b1}, 1'b1, rx, n[2]);
      byte_io(8'hFF, 1'b0, data[7:0], d);
      byte_io(8'hFF, 1'b1, data[15:8], d);
      stop_cond();
      nak = |n;
   endtask : read_word
endmodule : casr_host

// File: tb/test_charger_alert_status_regs.sv
`timescale 1ns/100ps
`include "casr_consts.svh"
module test_charger_alert_status_regs;
   // ============
   // bench signals
   logic       clock;
   logic       srst;
   logic [7:0] chg_ev;
   logic [5:0] reg_act;
   logic       chg_on;
   logic       meas_on;
   logic       pin_a;
   logic       pin_b;
   logic       scl;
   logic       host_oe_n;
   logic       dut_oe_n;
   logic       sda_out;
   logic       inhibit;
   int         num_errors;
   int         samples_checked;
   wire        sda = host_oe_n & (dut_oe_n | sda_out);

   casr_regs dut (
      .clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(dut_oe_n),
      .in_precharge(chg_ev[7]), .main_phase_flag(chg_ev[6]),
      .in_ntc_pause(chg_ev[5]), .in_timer_term(chg_ev[4]),
      .in_cx_term(chg_ev[3]), .in_max_time_fault(chg_ev[2]),
      .bat_missing(chg_ev[1]), .bat_short(chg_ev[0]),
      .regulation_active(reg_act), .charger_active(chg_on),
      .measure_enabled(meas_on), .stack_size_pin_a(pin_a),
      .stack_size_pin_b(pin_b), .charge_inhibit(inhibit)
   );
   casr_host host (
      .clock(clock), .sda(sda), .scl(scl), .sda_oe_n(host_oe_n)
   );

   always #5 clock = ~clock;

   // ============
   // helpers
   task automatic chk16(input string name, input logic [15:0] exp,
                        input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk16

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc

   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      logic nak;
      host.write_word(`CASR_SLAVE_ADDR, cmd, d, nak);
      chk16("write ack", 16'h0000, {15'h0000, nak});
   endtask : wr

   task automatic rd(input string name, input logic [7:0] cmd,
                     input logic [15:0] exp);
      logic        nak;
      logic [15:0] d;
      host.read_word(`CASR_SLAVE_ADDR, cmd, d, nak);
      chk16("read ack", 16'h0000, {15'h0000, nak});
      chk16(name, exp, d);
   endtask : rd

   // levels rise then fall: alerts must outlive their cause
   task automatic pulse(input logic [7:0] c, input logic [5:0] r);
      chg_ev <= c;
      reg_act <= r;
      cyc(4);
      chg_ev <= 8'h00;
      reg_act <= 6'h00;
      cyc(4);
   endtask : pulse

   // ============
   // scenarios
   task automatic t_reset();
      rd("chg alerts", `CASR_CMD_CHG_STATE, 16'h0000);
      rd("reg alerts", `CASR_CMD_REG_STATUS, 16'h0000);
   endtask : t_reset

   task automatic t_chg_each();
      wr(`CASR_CMD_EN_CHG_STATE, 16'h00FF);
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i, 6'h00);
         rd("chg bit", `CASR_CMD_CHG_STATE, 16'h0001 << i);
         wr(`CASR_CMD_CHG_STATE, ~(16'h0001 << i));
      end
      rd("chg none", `CASR_CMD_CHG_STATE, 16'h0000);
   endtask : t_chg_each

   task automatic t_clear_keep();
      pulse(8'hFF, 6'h00);
      rd("chg all", `CASR_CMD_CHG_STATE, 16'h00FF);
      wr(`CASR_CMD_CHG_STATE, 16'hFFF7);
      rd("chg one clr", `CASR_CMD_CHG_STATE, 16'h00F7);
      wr(`CASR_CMD_EN_CHG_STATE, 16'h00FE);
      rd("chg enable", `CASR_CMD_EN_CHG_STATE, 16'h00FE);
      rd("chg disable", `CASR_CMD_CHG_STATE, 16'h00F6);
      pulse(8'h01, 6'h00);
      wr(`CASR_CMD_EN_CHG_STATE, 16'h00FF);
      rd("chg masked", `CASR_CMD_CHG_STATE, 16'h00F6);
   endtask : t_clear_keep

   task automatic t_regulation();
      wr(`CASR_CMD_EN_REG_STATUS, 16'h003F);
      pulse(8'h00, 6'h2A);
      rd("reg set", `CASR_CMD_REG_STATUS, 16'h002A);
      wr(`CASR_CMD_EN_REG_STATUS, 16'h001F);
      rd("reg enable", `CASR_CMD_EN_REG_STATUS, 16'h001F);
      rd("reg disable", `CASR_CMD_REG_STATUS, 16'h000A);
      pulse(8'h00, 6'h3F);
      rd("reg masked", `CASR_CMD_REG_STATUS, 16'h001F);
      wr(`CASR_CMD_REG_STATUS, 16'hFFFE);
      rd("reg clr", `CASR_CMD_REG_STATUS, 16'h001E);
   endtask : t_regulation

   task automatic t_status();
      chg_on <= 1'b1;
      cyc(5);
      rd("sys active", `CASR_CMD_SYS_STATUS, 16'h0100);
      pin_a <= 1'b1;
      pin_b <= 1'b1;
      cyc(5);
      chk16("inhibit on", 16'h0001, {15'h0000, inhibit});
      wr(`CASR_CMD_SYS_STATUS, 16'h0000);
      rd("sys cells", `CASR_CMD_SYS_STATUS, 16'h0180);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      chg_on <= 1'b0;
      meas_on <= 1'b0;
      cyc(5);
      chk16("inhibit off", 16'h0000, {15'h0000, inhibit});
      rd("sys no meas", `CASR_CMD_SYS_STATUS, 16'h0080);
   endtask : t_status

   // a foreign address must stay unanswered, so the pull-up reads back
   task automatic t_refused();
      logic        nak;
      logic [15:0] d;
      host.read_word(`CASR_SLAVE_ADDR ^ 7'h01, `CASR_CMD_CHG_STATE, d, nak);
      chk16("foreign nak", 16'h0001, {15'h0000, nak});
      chk16("foreign data", 16'hFFFF, d);
      rd("unmapped", 8'h00, 16'h0000);
   endtask : t_refused

   // ============
   // run control
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   initial begin
      // traffic needs roughly 40k cycles; allow half again
      cyc(60000);
      num_errors++;
      finish_test();
   end

   initial begin
      clock = 1'b0;
      srst = 1'b1;
      chg_ev = 8'h00;
      reg_act = 6'h00;
      chg_on = 1'b0;
      meas_on = 1'b1;
      pin_a = 1'b0;
      pin_b = 1'b0;
      num_errors = 0;
      samples_checked = 0;
      cyc(2);
      srst <= 1'b0;
      cyc(4);
      t_reset();
      t_chg_each();
      t_clear_keep();
      t_regulation();
      t_status();
      t_refused();
      finish_test();
   end
endmodule : test_charger_alert_status_regs
